// file: common/smch_pkg.sv
// shared constants and carrier types for the stop-mode and contact-hold block
package smch_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned DELAY_UNIT_S = 1;
	localparam int unsigned CYC_PER_SEC = DELAY_UNIT_S * CLK_HZ;

	// stop-method codes
	localparam logic [15:0] STOP_RAMP_A    = 16'h270f;  // 9999
	localparam logic [15:0] STOP_RAMP_B    = 16'h22b8;  // 8888
	localparam logic [15:0] STOP_SHORT_MAX = 16'h0064;  // 100 s
	localparam logic [15:0] STOP_LONG_MIN  = 16'h03e8;  // 1000
	localparam logic [15:0] STOP_LONG_MAX  = 16'h044c;  // 1100
	localparam logic [15:0] CODE_NONE      = 16'h270f;  // 9999 sentinel

	// frequencies in 0.01 Hz units
	localparam logic [15:0] HOLD_FREQ_MAX  = 16'h0bb8;  // 30 Hz
	localparam logic [15:0] HOLD_CARR_FREQ = 16'h012c;  // 3 Hz
	localparam logic [15:0] LOW_FREQ_RST   = 16'h03e8;  // 10 Hz default

	// contact-hold select value that enables the feature
	localparam logic        HOLD_SEL_ON = 1'b1;

	// output reset values
	localparam logic [15:0] FREQ_RST  = 16'h0000;
	localparam logic [15:0] LEVEL_RST = 16'h0000;
	localparam logic [3:0]  CARR_RST  = 4'h0;

	// stored settings, all on the block's own clock
	typedef struct packed {
		logic [15:0] stop_method_setting;
		logic        contact_hold_select;
		logic [15:0] low_speed_frequency;
		logic [15:0] second_stall_level;
		logic [15:0] normal_stall_level;
		logic [15:0] low_speed_excitation_factor;
		logic [15:0] contact_hold_carrier_select;
		logic [3:0]  normal_carrier_select;
		logic [15:0] starting_frequency;
	} smch_cfg_s;

	// operating conditions that override stop method or contact hold
	typedef struct packed {
		logic power_fail_stop;
		logic panel_stop;
		logic comm_err_stop;
		logic net_estop;
		logic panel_op;
		logic jog_op;
		logic panel_ext_op;
		logic pid_op;
		logic remote_set_op;
		logic auto_accel_op;
	} smch_cond_s;

	// sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_RUN   = 5'b00010,
		ST_DECEL = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_FREE  = 5'b10000
	} smch_state_e;
endpackage : smch_pkg

// file: rtl/smch_sync.sv
// two-flop synchroniser for the contact input pins
`timescale 1ns/100ps
`default_nettype none
module smch_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	for (genvar g = 0; g < W; g++) begin : g_bit
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				meta_r[g] <= 1'b0;
				sync_o[g] <= 1'b0;
			end else if (ce_i) begin
				meta_r[g] <= pin_i[g];
				sync_o[g] <= meta_r[g];
			end
		end
	end
endmodule : smch_sync
`default_nettype wire

// file: rtl/smch_timer.sv
// whole-second coast delay timer with load and cancel
`timescale 1ns/100ps
`default_nettype none
module smch_timer #(
	parameter int unsigned CYC_PER_SEC = 100
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       start_i,
	input  wire logic       cancel_i,
	input  wire logic [6:0] secs_i,
	output logic            done_o
);
	logic [31:0] pre_r;
	logic [6:0]  rem_r;
	logic        busy_r;

	// a fresh start always reloads, so each release counts from zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_r  <= 32'h0;
			rem_r  <= 7'h0;
			busy_r <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			if (start_i) begin
				pre_r  <= 32'h0;
				rem_r  <= secs_i;
				busy_r <= 1'b1;
				done_o <= 1'b0;
			end else if (cancel_i) begin
				busy_r <= 1'b0;
				done_o <= 1'b0;
			end else if (busy_r) begin
				if (rem_r == 7'h0) begin
					busy_r <= 1'b0;
					done_o <= 1'b1;
				end else if (pre_r == CYC_PER_SEC - 1) begin
					pre_r <= 32'h0;
					rem_r <= rem_r - 7'h1;
				end else begin
					pre_r <= pre_r + 32'h1;
				end
			end
		end
	end
endmodule : smch_timer
`default_nettype wire

// file: rtl/smch_top.sv
// stop-method sequencer and contact-hold selection for the motor drive
// What this block does
// [R1] ramp codes 9999/8888: decelerate to zero once run command drops
// [R2] codes 1000..1100: shut output off setting-minus-1000 seconds after release
// [R3] coast mode: keep driving through the delay, then shut output off
// [R4] running indication drops together with output shutoff
// [R5] power-fail, panel, comm-error or network stops override stop method
// [R6] run again while coasting restarts from the starting frequency
// [R7] contact hold only when its select setting equals one
// [R8] low-speed setting is the contact-hold frequency, 0..400 Hz
// [R9] contact-hold frequency clamped to 30 Hz
// [R10] hold entered when both inputs on, any order; left when either drops
// [R11] hold frequency replaces whatever speed was running before
// [R12] hold uses second stall level; 9999 falls back to normal level
// [R13] hold at 3 Hz or less uses hold carrier; 9999 keeps normal
// [R14] excitation factor only under advanced flux vector; 9999 means none
// [R15] hold disabled in panel, jog, panel+ext, PID, remote, auto accel
// [R16] controller selects terminal operation and flux vector control first
// [R17] settings 0..100 s: coast to stop after that delay from release
// [R18] coast timer restarts on each release and cancels on re-run
`timescale 1ns/100ps
`default_nettype none
module smch_top
	import smch_pkg::*;
#(
	parameter int unsigned CYC_PER_SEC = smch_pkg::CYC_PER_SEC
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire logic                 forward_run_cmd_i,
	input  wire logic                 reverse_run_cmd_i,
	input  wire logic                 low_speed_input_i,
	input  wire logic                 second_function_input_i,
	input  wire smch_pkg::smch_cfg_s  cfg_i,
	input  wire smch_pkg::smch_cond_s cond_i,
	input  wire logic                 adv_flux_vector_i,
	input  wire logic [15:0]          set_frequency_i,
	input  wire logic [15:0]          output_frequency_i,
	output logic                      running_o,
	output logic                      output_shutoff_o,
	output logic                      decel_req_o,
	output logic                      start_load_o,
	output logic                      hold_active_o,
	output logic [15:0]               freq_cmd_o,
	output logic [15:0]               stall_level_o,
	output logic [3:0]                carrier_sel_o,
	output logic [15:0]               excitation_o,
	output logic                      excitation_en_o,
	output logic                      fast_limit_en_o
);
	import smch_pkg::*;

	smch_state_e state_r;
	smch_state_e state_nxt;
	logic [3:0]  pins_s;
	logic        run_cmd;
	logic        ramp_code;
	logic        long_code;
	logic        short_code;
	logic [6:0]  delay_secs;
	logic        stop_override;
	logic        hold_inhibit;
	logic        hold_nxt;
	logic        tmr_start;
	logic        tmr_cancel;
	logic        tmr_done;
	logic        start_nxt;
	logic [15:0] hold_freq;
	logic [15:0] sm_minus;

	// pins come from the machine controller, outside this clock
	smch_sync #(
		.W(4)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.pin_i  ({forward_run_cmd_i, reverse_run_cmd_i,
			low_speed_input_i, second_function_input_i}),
		.sync_o (pins_s)
	);

	assign run_cmd = pins_s[3] | pins_s[2];

	// stop-method decode
	assign sm_minus   = cfg_i.stop_method_setting - STOP_LONG_MIN;
	assign ramp_code  = (cfg_i.stop_method_setting == STOP_RAMP_A) ||
		(cfg_i.stop_method_setting == STOP_RAMP_B); // [R1]
	assign long_code  = (cfg_i.stop_method_setting >= STOP_LONG_MIN) &&
		(cfg_i.stop_method_setting <= STOP_LONG_MAX); // [R2]
	assign short_code = cfg_i.stop_method_setting <= STOP_SHORT_MAX; // [R17]
	assign delay_secs = long_code ? sm_minus[6:0]
		: cfg_i.stop_method_setting[6:0]; // [R2]

	// any of these stops takes over and the stop method is ignored
	assign stop_override = cond_i.power_fail_stop | cond_i.panel_stop |
		cond_i.comm_err_stop | cond_i.net_estop; // [R5]

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (run_cmd)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!run_cmd) begin
					if (stop_override || ramp_code) // [R1] [R5]
						state_nxt = ST_DECEL;
					else if (long_code || short_code) // [R3] [R17]
						state_nxt = ST_WAIT;
					else
						state_nxt = ST_DECEL;
				end
			end
			ST_WAIT: begin
				if (run_cmd)
					state_nxt = ST_RUN; // [R18]
				else if (stop_override)
					state_nxt = ST_DECEL; // [R5]
				else if (tmr_done)
					state_nxt = ST_FREE; // [R3]
			end
			ST_DECEL: begin
				if (run_cmd)
					state_nxt = ST_RUN;
				else if (output_frequency_i == FREQ_RST)
					state_nxt = ST_IDLE;
			end
			ST_FREE: begin
				if (run_cmd)
					state_nxt = ST_RUN; // [R6]
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// timer is reloaded on every release and dropped when run returns
	assign tmr_start  = (state_r == ST_RUN) && (state_nxt == ST_WAIT); // [R18]
	assign tmr_cancel = (state_r == ST_WAIT) && (state_nxt != ST_WAIT); // [R18]
	assign start_nxt  = (state_r == ST_FREE || state_r == ST_IDLE) &&
		(state_nxt == ST_RUN); // [R6]

	smch_timer #(
		.CYC_PER_SEC(CYC_PER_SEC)
	) u_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.ce_i     (ce_i),
		.start_i  (tmr_start),
		.cancel_i (tmr_cancel),
		.secs_i   (delay_secs),
		.done_o   (tmr_done)
	);

	// contact-hold qualification
	assign hold_inhibit = cond_i.panel_op | cond_i.jog_op |
		cond_i.panel_ext_op | cond_i.pid_op | cond_i.remote_set_op |
		cond_i.auto_accel_op; // [R15]
	assign hold_nxt = (cfg_i.contact_hold_select == HOLD_SEL_ON) && // [R7]
		pins_s[1] && pins_s[0] && !hold_inhibit; // [R10]
	assign hold_freq = (cfg_i.low_speed_frequency > HOLD_FREQ_MAX) ?
		HOLD_FREQ_MAX : cfg_i.low_speed_frequency; // [R8] [R9]

	// sequencer state register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_r <= ST_IDLE;
		else if (ce_i)
			state_r <= state_nxt;
	end

	// run indication and shutoff change together, never apart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			running_o        <= 1'b0;
			output_shutoff_o <= 1'b1;
			decel_req_o      <= 1'b0;
			start_load_o     <= 1'b0;
		end else if (ce_i) begin
			running_o        <= (state_nxt == ST_RUN) ||
				(state_nxt == ST_WAIT) || (state_nxt == ST_DECEL); // [R4]
			output_shutoff_o <= (state_nxt == ST_FREE) ||
				(state_nxt == ST_IDLE); // [R3] [R4]
			decel_req_o      <= state_nxt == ST_DECEL; // [R1]
			start_load_o     <= start_nxt; // [R6]
		end
	end

	// frequency command: start pulse, then hold or normal reference
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_active_o <= 1'b0;
			freq_cmd_o    <= FREQ_RST;
		end else if (ce_i) begin
			hold_active_o <= hold_nxt; // [R10]
			if (start_nxt)
				freq_cmd_o <= cfg_i.starting_frequency; // [R6]
			else if (hold_nxt)
				freq_cmd_o <= hold_freq; // [R11]
			else
				freq_cmd_o <= set_frequency_i;
		end
	end

	// stall, carrier, excitation and fast current limit selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stall_level_o   <= LEVEL_RST;
			carrier_sel_o   <= CARR_RST;
			excitation_o    <= LEVEL_RST;
			excitation_en_o <= 1'b0;
			fast_limit_en_o <= 1'b1;
		end else if (ce_i) begin
			if (hold_nxt && cfg_i.second_stall_level != CODE_NONE)
				stall_level_o <= cfg_i.second_stall_level; // [R12]
			else
				stall_level_o <= cfg_i.normal_stall_level; // [R12]
			// carrier swap waits for low speed to avoid audible steps
			if (hold_nxt && output_frequency_i <= HOLD_CARR_FREQ &&
				cfg_i.contact_hold_carrier_select != CODE_NONE)
				carrier_sel_o <= cfg_i.contact_hold_carrier_select[3:0]; // [R13]
			else
				carrier_sel_o <= cfg_i.normal_carrier_select; // [R13]
			// excitation boost only meaningful under advanced flux vector
			excitation_en_o <= adv_flux_vector_i &&
				cfg_i.low_speed_excitation_factor != CODE_NONE; // [R14]
			excitation_o    <= cfg_i.low_speed_excitation_factor; // [R14]
			fast_limit_en_o <= !hold_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_release_coast;
		ce_i && state_r == ST_RUN && !run_cmd && !stop_override &&
			!ramp_code && (long_code || short_code);
	endsequence

	sequence s_rerun_coasting;
		ce_i && state_r == ST_FREE && run_cmd;
	endsequence

	a_ramp_stop: assert property ( // [R1]
		ce_i && state_r == ST_RUN && !run_cmd && ramp_code
		|=> decel_req_o && running_o)
		else $error("ramp code did not start deceleration");

	a_coast_wait: assert property ( // [R3]
		s_release_coast |=> state_r == ST_WAIT && running_o &&
			!output_shutoff_o)
		else $error("coast release did not keep driving");

	a_shutoff_run: assert property ( // [R4]
		output_shutoff_o |-> !running_o)
		else $error("running shown while output shut off");

	a_override_stop: assert property ( // [R5]
		ce_i && state_r == ST_WAIT && !run_cmd && stop_override
		|=> decel_req_o)
		else $error("override stop did not decelerate");

	a_restart_freq: assert property ( // [R6]
		s_rerun_coasting |=> start_load_o &&
			freq_cmd_o == $past(cfg_i.starting_frequency))
		else $error("restart not at starting frequency");

	a_hold_select: assert property ( // [R7]
		ce_i && cfg_i.contact_hold_select != HOLD_SEL_ON |=> !hold_active_o)
		else $error("hold active without select");

	a_hold_clamp: assert property ( // [R9]
		hold_active_o && !start_load_o |-> freq_cmd_o <= HOLD_FREQ_MAX)
		else $error("hold frequency above clamp");

	a_hold_inhibit: assert property ( // [R15]
		ce_i && hold_inhibit |=> !hold_active_o && fast_limit_en_o)
		else $error("hold active under inhibit");

	a_timer_cancel: assert property ( // [R18]
		ce_i && state_r == ST_WAIT && run_cmd |=> state_r == ST_RUN
			&& !output_shutoff_o)
		else $error("re-run did not cancel coast delay");

	// expiry of the delay is the only way out of the wait into freewheel
	a_coast_expiry: assert property ( // [R3]
		ce_i && state_r == ST_WAIT && !run_cmd && !stop_override &&
			tmr_done
		|=> output_shutoff_o && !running_o)
		else $error("coast delay end did not shut output off");

	// second stall level taken in hold unless the fall-back code is set
	a_stall_second: assert property ( // [R12]
		ce_i && hold_nxt && cfg_i.second_stall_level != CODE_NONE
		|=> stall_level_o == $past(cfg_i.second_stall_level))
		else $error("hold did not use second stall level");

	// hold carrier must never leak into normal operation
	a_carrier_normal: assert property ( // [R13]
		ce_i && !hold_nxt
		|=> carrier_sel_o == $past(cfg_i.normal_carrier_select))
		else $error("hold carrier used outside hold");

	// excitation boost is gated by the control method, not by hold
	a_excite_gate: assert property ( // [R14]
		ce_i && !adv_flux_vector_i |=> !excitation_en_o)
		else $error("excitation applied outside flux vector");
endmodule : smch_top
`default_nettype wire

// file: test/smch_ctrl_model.sv
// contact-input model of the machine controller driving the drive pins
`timescale 1ns/100ps
`default_nettype none
module smch_ctrl_model (
	input  wire logic clk_i,
	output logic      fwd_o,
	output logic      rev_o,
	output logic      low_o,
	output logic      sec_o,
	output logic      flux_o
);
	// terminal operation with flux vector control chosen before any use
	initial begin
		{fwd_o, rev_o, low_o, sec_o} = 4'h0;
		flux_o = 1'b1;
	end

	// pins move just after an edge, like a relay output would
	task pins(input logic [3:0] v);
		@(posedge clk_i);
		{fwd_o, rev_o, low_o, sec_o} <= v;
	endtask : pins

	// control method switch, also only after an edge
	task flux(input logic v);
		@(posedge clk_i);
		flux_o <= v;
	endtask : flux
endmodule : smch_ctrl_model
`default_nettype wire

// file: test/smch_top_tb.sv
// self-checking bench for the stop-mode and contact-hold block
`timescale 1ns/100ps
`default_nettype none
module smch_top_tb;
	import smch_pkg::*;
	localparam int unsigned CPS    = 10;
	localparam int unsigned LIMIT  = 5000;
	localparam logic [15:0] SETF   = 16'h1388;
	localparam logic [15:0] STARTF = 16'h0032;
	logic        clk_i, rst_i, fwd, rev, low, sec, flux;
	smch_cfg_s   cfg;
	smch_cond_s  cond;
	logic [15:0] ofreq, freq, stall, exc;
	logic [15:0] setf;
	logic        ce;
	logic        running, shutoff, decel, sload, hold, exc_en, fast;
	logic [3:0]  carr;
	int          failures, n_compared;
	int          cycles = 0;

	smch_ctrl_model ctl (.clk_i(clk_i), .fwd_o(fwd), .rev_o(rev),
		.low_o(low), .sec_o(sec), .flux_o(flux));

	smch_top #(.CYC_PER_SEC(CPS)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .forward_run_cmd_i(fwd), .reverse_run_cmd_i(rev),
		.low_speed_input_i(low), .second_function_input_i(sec),
		.cfg_i(cfg), .cond_i(cond), .adv_flux_vector_i(flux),
		.set_frequency_i(setf), .output_frequency_i(ofreq),
		.running_o(running), .output_shutoff_o(shutoff),
		.decel_req_o(decel), .start_load_o(sload), .hold_active_o(hold),
		.freq_cmd_o(freq), .stall_level_o(stall), .carrier_sel_o(carr),
		.excitation_o(exc), .excitation_en_o(exc_en),
		.fast_limit_en_o(fast));

	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// hang guard: a stuck wait ends the run as a failure
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			print_verdict();
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// wait edges, then step off the edge so registered outputs have landed
	task go(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : go

	// start from stop: one-cycle starting frequency, then the reference
	task start;
		ctl.pins(4'h8);
		go(3);
		chk(sload, 1'b1);
		chk(freq, STARTF);
		chk({running, shutoff}, 2'b10);
		go(1);
		chk(sload, 1'b0);
		chk(freq, SETF);
	endtask : start

	// release run under a ramp code or an override, then reach zero speed
	task ramp(input logic [15:0] code, input logic [9:0] c);
		@(posedge clk_i);
		cfg.stop_method_setting <= code;
		cond <= c;
		ctl.pins(4'h0);
		go(3);
		chk({decel, running, shutoff}, 3'b110);
		@(posedge clk_i);
		ofreq <= 16'h0000;
		go(1);
		chk({decel, running, shutoff}, 3'b001);
		@(posedge clk_i);
		ofreq <= 16'h01f4;
		cond <= '0;
		start();
	endtask : ramp

	// release run under a coast code and time the shutoff
	task coast(input logic [15:0] code, input int secs);
		int n;
		@(posedge clk_i);
		cfg.stop_method_setting <= code;
		ctl.pins(4'h0);
		go(3);
		chk({running, shutoff}, 2'b10);
		n = 0;
		while (shutoff !== 1'b1 && n < 300) begin
			go(1);
			n++;
		end
		chk(n >= secs * CPS && n <= secs * CPS + 3, 1'b1);
		chk(running, 1'b0);
		start();
	endtask : coast

	// main sequence
	initial begin
		rst_i = 1'b1;
		ce = 1'b1;
		setf = SETF;
		failures = 0;
		n_compared = 0;
		cond = '0;
		cfg = '0;
		ofreq = 16'h01f4;
		cfg.stop_method_setting = STOP_RAMP_A;
		cfg.contact_hold_select = 1'b1;
		cfg.low_speed_frequency = 16'h0fa0;
		cfg.second_stall_level = 16'h0096;
		cfg.normal_stall_level = 16'h0078;
		cfg.low_speed_excitation_factor = 16'h0096;
		cfg.contact_hold_carrier_select = 16'h0005;
		cfg.normal_carrier_select = 4'h2;
		cfg.starting_frequency = STARTF;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		go(1);
		chk({running, shutoff, fast}, 3'b011);
		start();
		// a low clock enable freezes outputs while pins and reference move
		@(posedge clk_i);
		ce <= 1'b0;
		setf <= 16'h0bb8;
		ctl.pins(4'h0);
		go(6);
		chk({decel, running, shutoff}, 3'b010);
		chk(freq, SETF);
		@(posedge clk_i);
		ce <= 1'b1;
		go(1);
		chk(freq, 16'h0bb8);
		go(2);
		chk({decel, running, shutoff}, 3'b110);
		@(posedge clk_i);
		setf <= SETF;
		ofreq <= 16'h0000;
		go(1);
		chk({decel, running, shutoff}, 3'b001);
		@(posedge clk_i);
		ofreq <= 16'h01f4;
		start();
		ramp(STOP_RAMP_A, '0);
		ramp(STOP_RAMP_B, '0);
		for (int i = 0; i < 4; i++) begin
			ramp(16'h03ea, 10'h200 >> i);
		end
		coast(16'h03ea, 2);
		coast(16'h0005, 5);
		coast(16'h0000, 0);
		// an override arriving during the coast delay turns it into a ramp
		@(posedge clk_i);
		cfg.stop_method_setting <= 16'h03ea;
		ctl.pins(4'h0);
		go(5);
		@(posedge clk_i);
		cond <= 10'h040;
		go(1);
		chk({decel, running, shutoff}, 3'b110);
		@(posedge clk_i);
		ofreq <= 16'h0000;
		cond <= '0;
		go(1);
		chk({decel, running, shutoff}, 3'b001);
		@(posedge clk_i);
		ofreq <= 16'h01f4;
		start();
		// re-run inside a 2 s delay, on the reverse pin, cancels the timer;
		// the check falls after the edge on which the delay would have ended
		@(posedge clk_i);
		cfg.stop_method_setting <= 16'h03ea;
		ctl.pins(4'h0);
		go(3 + CPS);
		chk({running, shutoff}, 2'b10);
		ctl.pins(4'h4);
		go(12);
		chk({running, shutoff, sload}, 3'b100);
		coast(16'h03ea, 2);
		// contact hold entered in either order, left when one input drops
		for (int o = 0; o < 2; o++) begin
			ctl.pins(o ? 4'ha : 4'h9);
			go(5);
			chk(hold, 1'b0);
			ctl.pins(4'hb);
			go(3);
			chk(hold, 1'b1);
			chk(freq, HOLD_FREQ_MAX);
			chk(stall, 16'h0096);
			chk(fast, 1'b0);
			ctl.pins(o ? 4'h9 : 4'ha);
			go(3);
			chk(hold, 1'b0);
			chk(freq, SETF);
			chk(stall, 16'h0078);
			chk(fast, 1'b1);
		end
		ctl.pins(4'hb);
		@(posedge clk_i);
		ofreq <= 16'h012c;
		cfg.second_stall_level <= CODE_NONE;
		cfg.low_speed_frequency <= 16'h03e8;
		go(4);
		chk(carr, 4'h5);
		chk(stall, 16'h0078);
		chk(freq, 16'h03e8);
		@(posedge clk_i);
		ofreq <= 16'h012d;
		go(2);
		chk(carr, 4'h2);
		@(posedge clk_i);
		ofreq <= 16'h012c;
		cfg.contact_hold_carrier_select <= CODE_NONE;
		go(2);
		chk(carr, 4'h2);
		// each inhibit in turn, then select off, with both inputs held on
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_i);
			cfg.contact_hold_select <= (i == 6) ? 1'b0 : 1'b1;
			cond <= (i < 6) ? (10'h001 << i) : '0;
			go(2);
			chk(hold, 1'b0);
		end
		@(posedge clk_i);
		cfg.contact_hold_select <= 1'b1;
		go(2);
		chk(hold, 1'b1);
		chk({exc_en, carr}, 5'h12);
		chk(exc, 16'h0096);
		ctl.flux(1'b0);
		go(2);
		chk(exc_en, 1'b0);
		ctl.flux(1'b1);
		@(posedge clk_i);
		cfg.low_speed_excitation_factor <= CODE_NONE;
		go(2);
		chk(exc_en, 1'b0);
		print_verdict();
	end
endmodule : smch_top_tb
`default_nettype wire
